//--- rtl/epr_cmd.sv
// Serial command interpreter: border, end option, readback select,
// RAM window and address counter, and regular-pattern fill.
// Assumes raw host pins arrive asynchronously; RAMs live outside.
// How it works
// - Border byte mode bits; reset selects high impedance
// - Fixed-level mode bits 5:4 pick level
// - Transition mode bits 1:0 pick table
// - End option 07h holds source outputs
// - Readback bit 0 picks black/white or red
// - X window first byte sets start column
// - X window second byte sets end column
// - Y window four bytes, low then bit 8
// - Y window end row resets to 127h
// - Red fill command fills red RAM, busy
// - Black/white fill; step codes map to sizes
// - Strap picks four-wire or three-wire link
// - Three-wire frames: flag bit then byte
// - Four-wire: MSB first, pin level per byte
`include "epr_consts.svh"
module epr_cmd
  import epr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       cs_b_pin,
  input  wire logic       sclk_pin,
  input  wire logic       sdi_pin,
  input  wire logic       dc_pin,
  input  wire logic       interface_select_strap,
  output epr_border_t     border_r,
  output logic            hold_source_r,
  output logic            read_red_r,
  output epr_win_t        win_r,
  output epr_addr_t       ram_address_counter_r,
  output logic            three_wire_r,
  output logic            busy_r,
  output logic            fill_we_r,
  output logic            fill_red_r,
  output epr_addr_t       fill_addr_r,
  output logic [7:0]      fill_data_r
);
  logic [`EPR_PINS-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [3:0]           bit_r;
  logic [6:0]           sh_r;
  logic                 flag_r;
  logic                 byte_v_r;
  logic [7:0]           byte_r;
  logic                 is_data_r;
  logic [7:0]           cmd_r;
  logic [1:0]           idx_r;
  logic                 full_r;
  logic                 fill_go_r;
  logic                 fill_go_red_r;
  logic [7:0]           fill_par_r;
  logic                 sck_rise;
  logic                 sdi;
  logic [3:0]           last_bit;
  epr_fill_st_t         fill_st;

  // Three flops per pin; a level counts once stages two and three agree
  for (genvar g = 0; g < `EPR_PINS; g++) begin : g_sync
    always_ff @(posedge clk or negedge rst_b) begin
      // Reset to idle levels; a strap stage reset high would flash three-wire mode
      if (!rst_b) begin
        s1_r[g]  <= 1'(g == `EPR_PIN_CS);
        s2_r[g]  <= 1'(g == `EPR_PIN_CS);
        s3_r[g]  <= 1'(g == `EPR_PIN_CS);
        lvl_r[g] <= 1'(g == `EPR_PIN_CS);
      end else begin
        s1_r[g] <= (g == `EPR_PIN_CS) ? cs_b_pin :
                   (g == `EPR_PIN_SCK) ? sclk_pin :
                   (g == `EPR_PIN_SDI) ? sdi_pin :
                   (g == `EPR_PIN_DC) ? dc_pin : interface_select_strap;
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g]) begin
          lvl_r[g] <= s3_r[g];
        end
      end
    end
  end

  assign sck_rise = !lvl_r[`EPR_PIN_SCK] && s2_r[`EPR_PIN_SCK] && s3_r[`EPR_PIN_SCK];
  assign sdi      = s3_r[`EPR_PIN_SDI];
  assign last_bit = three_wire_r ? `EPR_BITS_3W : `EPR_BITS_4W;

  // Mode only changes while no frame is open, so a byte never mixes modes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      three_wire_r <= 1'b0;
    end else if (lvl_r[`EPR_PIN_CS] && s2_r[`EPR_PIN_STRAP] == s3_r[`EPR_PIN_STRAP]) begin
      three_wire_r <= s3_r[`EPR_PIN_STRAP];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_r     <= 4'h0;
      sh_r      <= 7'h00;
      flag_r    <= 1'b0;
      byte_v_r  <= 1'b0;
      byte_r    <= 8'h00;
      is_data_r <= 1'b0;
    end else begin
      byte_v_r <= 1'b0;
      if (lvl_r[`EPR_PIN_CS]) begin
        bit_r <= 4'h0;
      end else if (sck_rise) begin
        if (three_wire_r && bit_r == 4'h0) begin
          flag_r <= sdi;
          bit_r  <= 4'h1;
        end else if (bit_r == last_bit) begin
          bit_r     <= 4'h0;
          byte_v_r  <= 1'b1;
          byte_r    <= {sh_r, sdi};
          // Pin ignored in three-wire, the host holds it low there
          is_data_r <= three_wire_r ? flag_r : lvl_r[`EPR_PIN_DC];
        end else begin
          sh_r  <= {sh_r[5:0], sdi};
          bit_r <= bit_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r  <= `EPR_CMD_NOP;
      idx_r  <= 2'h0;
      full_r <= 1'b0;
    end else if (byte_v_r) begin
      if (!is_data_r) begin
        cmd_r  <= byte_r;
        idx_r  <= 2'h0;
        full_r <= 1'b0;
      end else if (idx_r != 2'h3) begin
        idx_r <= idx_r + 2'h1;
      end else begin
        full_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      border_r      <= `EPR_BORDER_RST;
      hold_source_r <= (`EPR_WAVEFORM_END_OPTION_RST == `EPR_WAVEFORM_END_OPTION_HOLD);
      read_red_r    <= 1'b0;
    end else if (byte_v_r && is_data_r && idx_r == 2'h0) begin
      if (cmd_r == `EPR_CMD_BORDER) begin
        border_r <= byte_r;
      end else if (cmd_r == `EPR_CMD_WAVEFORM_END_OPTION) begin
        hold_source_r <= (byte_r == `EPR_WAVEFORM_END_OPTION_HOLD);
      end else if (cmd_r == `EPR_CMD_RDOPT) begin
        read_red_r <= byte_r[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      win_r <= '{x_start: 6'h00, x_end: `EPR_XEND_RST,
                 y_start: 9'h000, y_end: `EPR_YEND_RST};
      ram_address_counter_r <= '0;
    end else if (byte_v_r && is_data_r) begin
      if (cmd_r == `EPR_CMD_XWIN) begin
        if (idx_r == 2'h0) begin
          win_r.x_start <= byte_r[5:0];
        end else if (idx_r == 2'h1) begin
          win_r.x_end <= byte_r[5:0];
        end
      end else if (cmd_r == `EPR_CMD_YWIN) begin
        case (idx_r)
          2'h0: win_r.y_start[7:0] <= byte_r;
          2'h1: win_r.y_start[8]   <= byte_r[0];
          2'h2: win_r.y_end[7:0]   <= byte_r;
          default: begin
            // Bytes past the fourth must not touch the end row
            if (!full_r) begin
              win_r.y_end[8] <= byte_r[0];
            end
          end
        endcase
      end else if (cmd_r == `EPR_CMD_XCNT && idx_r == 2'h0) begin
        ram_address_counter_r.x <= byte_r[5:0];
      end else if (cmd_r == `EPR_CMD_YCNT) begin
        if (idx_r == 2'h0) begin
          ram_address_counter_r.y[7:0] <= byte_r;
        end else if (idx_r == 2'h1) begin
          ram_address_counter_r.y[8] <= byte_r[0];
        end
      end
    end
  end

  // A fill request while one runs is dropped; the host must wait on busy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_go_r     <= 1'b0;
      fill_go_red_r <= 1'b0;
      fill_par_r    <= `EPR_FILL_RST;
    end else begin
      fill_go_r <= 1'b0;
      if (byte_v_r && is_data_r && idx_r == 2'h0 && fill_st == EPR_IDLE &&
          (cmd_r == `EPR_CMD_FILL_RED || cmd_r == `EPR_CMD_FILL_BW)) begin
        fill_go_r     <= 1'b1;
        fill_go_red_r <= (cmd_r == `EPR_CMD_FILL_RED);
        fill_par_r    <= byte_r;
      end
    end
  end

  epr_fill u_fill (
    .clk    (clk),
    .rst_b  (rst_b),
    .go     (fill_go_r),
    .red    (fill_go_red_r),
    .par    (fill_par_r),
    .st_r   (fill_st),
    .we_r   (fill_we_r),
    .red_r  (fill_red_r),
    .addr_r (fill_addr_r),
    .data_r (fill_data_r)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= fill_go_r || (fill_st == EPR_RUN) || fill_we_r;
    end
  end

  border_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
    byte_v_r && is_data_r && idx_r == 2'h0 && cmd_r == `EPR_CMD_BORDER
    |=> border_r.mode == $past(byte_r[7:6]))
    else $error("border mode not taken from parameter");
  border_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    byte_v_r && is_data_r && idx_r == 2'h0 && cmd_r == `EPR_CMD_BORDER
    |=> border_r.level == $past(byte_r[5:4]))
    else $error("border level not taken from parameter");
  border_lut_a: assert property (@(posedge clk) disable iff (!rst_b)
    byte_v_r && is_data_r && idx_r == 2'h0 && cmd_r == `EPR_CMD_BORDER
    |=> border_r.lut == $past(byte_r[1:0]))
    else $error("border table select wrong");
  waveform_end_option_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    byte_v_r && is_data_r && idx_r == 2'h0 && cmd_r == `EPR_CMD_WAVEFORM_END_OPTION
    |=> hold_source_r == ($past(byte_r) == `EPR_WAVEFORM_END_OPTION_HOLD))
    else $error("end option hold wrong");
  read_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
    byte_v_r && is_data_r && idx_r == 2'h0 && cmd_r == `EPR_CMD_RDOPT
    |=> read_red_r == $past(byte_r[0]))
    else $error("readback select wrong");
  xwin_end_a: assert property (@(posedge clk) disable iff (!rst_b)
    byte_v_r && is_data_r && idx_r == 2'h1 && cmd_r == `EPR_CMD_XWIN
    |=> win_r.x_end == $past(byte_r[5:0]) && $stable(win_r.x_start))
    else $error("x window end wrong");
  ywin_hi_a: assert property (@(posedge clk) disable iff (!rst_b)
    byte_v_r && is_data_r && idx_r == 2'h1 && cmd_r == `EPR_CMD_YWIN
    |=> win_r.y_start[8] == $past(byte_r[0]) && $stable(win_r.y_end))
    else $error("y window start bit 8 wrong");
  fill_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
    fill_go_r |=> busy_r [*8])
    else $error("busy not raised for fill");
  nop_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    byte_v_r && !is_data_r && byte_r == `EPR_CMD_NOP
    |=> $stable(border_r) && $stable(win_r) && !fill_go_r)
    else $error("no-operation changed state");
endmodule : epr_cmd

//--- rtl/epr_consts.svh
// Constants of the e-paper command interpreter: codes, reset values, counts.
// Included by the design modules and the bench; definitions only.
`ifndef EPR_CONSTS_SVH
`define EPR_CONSTS_SVH
`define EPR_CMD_BORDER    8'h3c
`define EPR_CMD_WAVEFORM_END_OPTION      8'h3f
`define EPR_CMD_RDOPT     8'h41
`define EPR_CMD_XWIN      8'h44
`define EPR_CMD_YWIN      8'h45
`define EPR_CMD_FILL_RED  8'h46
`define EPR_CMD_FILL_BW   8'h47
`define EPR_CMD_XCNT      8'h4e
`define EPR_CMD_YCNT      8'h4f
`define EPR_CMD_NOP       8'h7f
`define EPR_BORDER_RST    8'hc0
`define EPR_WAVEFORM_END_OPTION_RST      8'h02
`define EPR_WAVEFORM_END_OPTION_HOLD     8'h07
`define EPR_XEND_RST      6'h15
`define EPR_YEND_RST      9'h127
`define EPR_FILL_RST      8'h00
`define EPR_BITS_4W       4'h7
`define EPR_BITS_3W       4'h8
`define EPR_PIN_CS        0
`define EPR_PIN_SCK       1
`define EPR_PIN_SDI       2
`define EPR_PIN_DC        3
`define EPR_PIN_STRAP     4
`define EPR_PINS          5
`define EPR_FILL_ROWS     9'h0c8
`define EPR_FILL_XBYTES   6'h19
`define EPR_STEP_SHIFT0   3
`define EPR_STEP_BIG      3'h5
`endif

//--- rtl/epr_pkg.sv
// Types shared by the e-paper command interpreter and its fill engine.
// Assumes epr_consts.svh is on the include path.
package epr_pkg;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] level;
    logic       rsvd;
    logic       gs_ctl;
    logic [1:0] lut;
  } epr_border_t;

  typedef struct packed {
    logic [5:0] x_start;
    logic [5:0] x_end;
    logic [8:0] y_start;
    logic [8:0] y_end;
  } epr_win_t;

  typedef struct packed {
    logic [5:0] x;
    logic [8:0] y;
  } epr_addr_t;

  typedef enum logic {EPR_IDLE, EPR_RUN} epr_fill_st_t;
endpackage : epr_pkg

//--- rtl/epr_fill.sv
// Regular-pattern fill engine: walks every byte of one image RAM.
// Assumes a RAM outside that takes one byte per we_r pulse.
`include "epr_consts.svh"
module epr_fill
  import epr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       go,
  input  wire logic       red,
  input  wire logic [7:0] par,
  output epr_fill_st_t    st_r,
  output logic            we_r,
  output logic            red_r,
  output epr_addr_t       addr_r,
  output logic [7:0]      data_r
);
  logic [7:0] par_r;
  logic [5:0] xb_r;
  logic [8:0] y_r;
  logic [7:0] data_nxt;
  logic       last;

  // Codes 101 to 111 mean 200 pixels: the whole panel, so never toggles
  function automatic logic step_bit(input logic [8:0] pos, input logic [2:0] code);
    logic [8:0] sh;
    sh = pos >> (code + 3'(`EPR_STEP_SHIFT0));
    step_bit = (code >= `EPR_STEP_BIG) ? 1'b0 : sh[0];
  endfunction : step_bit

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      data_nxt[7-i] = par_r[7] ^ step_bit({xb_r, 3'(i)}, par_r[2:0])
                      ^ step_bit(y_r, par_r[6:4]);
    end
  end

  assign last = (xb_r == `EPR_FILL_XBYTES - 6'h01) && (y_r == `EPR_FILL_ROWS - 9'h001);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r  <= EPR_IDLE;
      par_r <= `EPR_FILL_RST;
      red_r <= 1'b0;
      xb_r  <= 6'h00;
      y_r   <= 9'h000;
    end else begin
      case (st_r)
        EPR_IDLE: begin
          if (go) begin
            st_r  <= EPR_RUN;
            par_r <= par;
            red_r <= red;
            xb_r  <= 6'h00;
            y_r   <= 9'h000;
          end
        end
        EPR_RUN: begin
          if (last) begin
            st_r <= EPR_IDLE;
          end else if (xb_r == `EPR_FILL_XBYTES - 6'h01) begin
            xb_r <= 6'h00;
            y_r  <= y_r + 9'h001;
          end else begin
            xb_r <= xb_r + 6'h01;
          end
        end
        default: st_r <= EPR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      we_r   <= 1'b0;
      addr_r <= '0;
      data_r <= 8'h00;
    end else begin
      we_r   <= (st_r == EPR_RUN);
      addr_r <= '{x: xb_r, y: y_r};
      data_r <= data_nxt;
    end
  end
endmodule : epr_fill

//--- tb/epr_host_model.sv
// Host-side serial master for the e-paper command interpreter.
// Assumes one clk; pins change just after rising clk edges.
module epr_host_model (
  input  wire logic clk,
  output logic      cs_b_pin,
  output logic      sclk_pin,
  output logic      sdi_pin,
  output logic      dc_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_b_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin  = 1'b0;
    dc_pin   = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask : gap

  task automatic open_frame();
    cs_b_pin <= 1'b0;
    gap(8);
  endtask : open_frame

  // Slow clock: 8 clk per phase leaves room for the pin synchroniser
  task automatic put_byte(input logic tw, input logic dat, input logic [7:0] b);
    logic [8:0] f;
    f = {dat, b};
    dc_pin <= tw ? 1'b0 : dat;
    for (int i = tw ? 8 : 7; i >= 0; i--) begin
      sdi_pin  <= f[i];
      sclk_pin <= 1'b0;
      gap(8);
      sclk_pin <= 1'b1;
      gap(8);
    end
    sclk_pin <= 1'b0;
    gap(8);
  endtask : put_byte

  task automatic close_frame();
    cs_b_pin <= 1'b1;
    // Released line must not keep showing the last bit
    sdi_pin  <= ~sdi_pin;
    gap(8);
  endtask : close_frame
endmodule : epr_host_model

//--- tb/tb_top.sv
// Self-checking bench of the e-paper command interpreter.
// Assumes epr_consts.svh on the include path; fill RAM is not modelled.
`include "epr_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import epr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b, strap, tw, cs_b, sclk, sdi, dc;
  logic        hold, rd_red, tw_r, busy, we, f_red, p_red;
  epr_border_t border;
  epr_win_t    win;
  epr_addr_t   cnt, f_addr;
  logic [7:0]  f_data, par;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          we_n = 0;

  always #2 clk = ~clk;

  epr_host_model i_epr_host_model (.clk(clk), .cs_b_pin(cs_b), .sclk_pin(sclk),
                                   .sdi_pin(sdi), .dc_pin(dc));
  epr_cmd i_epr_cmd (.clk(clk), .rst_b(rst_b), .cs_b_pin(cs_b), .sclk_pin(sclk),
    .sdi_pin(sdi), .dc_pin(dc), .interface_select_strap(strap), .border_r(border),
    .hold_source_r(hold), .read_red_r(rd_red), .win_r(win), .ram_address_counter_r(cnt),
    .three_wire_r(tw_r), .busy_r(busy), .fill_we_r(we), .fill_red_r(f_red),
    .fill_addr_r(f_addr), .fill_data_r(f_data));

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input logic [29:0] seen, input logic [29:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Sizes 200 never toggle inside the 200-pixel panel
  function automatic logic pix(input int xb, input int y);
    logic xt, yt;
    xt = (par[2:0] < 3'h5) ? 1'((xb >> par[2:0]) & 1) : 1'b0;
    yt = (par[6:4] < 3'h5) ? 1'((y >> (par[6:4] + 3)) & 1) : 1'b0;
    return par[7] ^ xt ^ yt;
  endfunction : pix

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 50000) begin
      $display("Error at %0t: timeout", $time);
      fails++;
      stop_test();
    end
    if (we === 1'b1) begin
      check({f_red, f_addr, f_data}, {p_red, 6'(we_n % 25), 9'(we_n / 25),
            {8{pix(we_n % 25, we_n / 25)}}});
      we_n++;
    end
  end

  task automatic send(input logic [7:0] c, input int n, input logic [31:0] ps);
    i_epr_host_model.open_frame();
    i_epr_host_model.put_byte(tw, 1'b0, c);
    for (int i = n - 1; i >= 0; i--) i_epr_host_model.put_byte(tw, 1'b1, ps[i*8 +: 8]);
    i_epr_host_model.close_frame();
  endtask : send

  task automatic t_reset();
    check(border, 8'hc0);
    check(hold, 1'b0);
    check(rd_red, 1'b0);
    check(win, {6'h00, 6'h15, 9'h000, 9'h127});
    check({cnt, busy, tw_r}, 17'h00000);
    $display("reset test done");
  endtask : t_reset

  task automatic t_regs();
    logic [1:0] k;
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      b = {k, k, 2'h0, k};
      // Trailing byte beyond the count must be ignored
      send(`EPR_CMD_BORDER, 2, {16'h0, b, 8'hff});
      check(border, b);
    end
    send(`EPR_CMD_WAVEFORM_END_OPTION, 1, 32'h07);
    check(hold, 1'b1);
    send(`EPR_CMD_WAVEFORM_END_OPTION, 1, 32'h02);
    check(hold, 1'b0);
    send(`EPR_CMD_RDOPT, 1, 32'h01);
    check(rd_red, 1'b1);
    send(`EPR_CMD_RDOPT, 1, 32'h00);
    check(rd_red, 1'b0);
    $display("register test done");
  endtask : t_regs

  task automatic t_window();
    send(`EPR_CMD_XWIN, 2, 32'hff2a);
    send(`EPR_CMD_YWIN, 4, 32'h3401c700);
    check(win, {6'h3f, 6'h2a, 9'h134, 9'h0c7});
    send(`EPR_CMD_XCNT, 1, 32'h2b);
    send(`EPR_CMD_YCNT, 2, 32'h5101);
    check(cnt, {6'h2b, 9'h151});
    send(`EPR_CMD_NOP, 1, 32'h0c);
    check(cnt, {6'h2b, 9'h151});
    $display("window test done");
  endtask : t_window

  task automatic t_fill(input logic red, input logic [7:0] p);
    par = p;
    p_red = red;
    we_n = 0;
    send(red ? `EPR_CMD_FILL_RED : `EPR_CMD_FILL_BW, 1, {24'h0, p});
    check(busy, 1'b1);
    // Second fill while busy must be dropped
    send(`EPR_CMD_FILL_RED, 1, 32'h00);
    for (int i = 0; i < 6000 && busy !== 1'b0; i++) @(posedge clk);
    check(we_n, 5000);
    check(busy, 1'b0);
    $display("fill test done");
  endtask : t_fill

  task automatic t_link();
    strap <= 1'b1;
    repeat (8) @(posedge clk);
    check(tw_r, 1'b1);
    tw = 1'b1;
    send(`EPR_CMD_BORDER, 1, 32'hc5);
    check(border, 8'hc5);
    strap <= 1'b0;
    tw = 1'b0;
    repeat (8) @(posedge clk);
    check(tw_r, 1'b0);
    send(`EPR_CMD_BORDER, 1, 32'h50);
    check(border, 8'h50);
    $display("link test done");
  endtask : t_link

  // Reset in mid-run must return every setting to its reset value
  task automatic t_midreset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    check(border, 8'hc0);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    $display("mid-run reset test done");
  endtask : t_midreset

  initial begin
    rst_b = 1'b0;
    strap = 1'b0;
    tw = 1'b0;
    par = 8'h00;
    p_red = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_regs();
    t_window();
    t_fill(1'b0, 8'h03);
    t_fill(1'b1, 8'ha4);
    t_fill(1'b0, 8'hd7);
    t_fill(1'b1, 8'h61);
    t_link();
    t_midreset();
    stop_test();
  end
endmodule : tb_top
